/* File: hdl/timebase_pkg.sv */
// timing constants, field widths, address map and states of the time base
// assumes a single 10 MHz system clock; all counts are in its cycles
package timebase_pkg;

  // =====================================================================
  // clock and timing
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          TW              = 32;
  localparam int          HOLD_MIN_NS     = 5000;
  localparam int          HOLD_MIN_CYC    =
    (HOLD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          AUTO_TRIG_MS    = 20;
  localparam int          AUTO_TRIG_CYC   = AUTO_TRIG_MS * (CLK_HZ / 1000);
  localparam int          REQ_HOLD_MAX_MS = 2500;
  localparam int          REQ_HOLD_MAX_CYC =
    REQ_HOLD_MAX_MS * (CLK_HZ / 1000);
  localparam int          DIVISIONS       = 10;

  // =====================================================================
  // strobe delay generator: fine part below one clock, coarse above
  localparam int          DLY_W           = 48;
  localparam int          FINE_W          = 30;
  localparam int          COARSE_W        = 6;
  localparam int          N_COARSE        = 3;
  localparam longint      CLK_PERIOD_FS   = 64'd1_000_000_000_000_000
                                            / CLK_HZ;
  localparam longint      DOT_MIN_FS      = 10;
  localparam longint      DOT_MAX_FS      = 20_000_000;
  localparam logic [DLY_W-1:0] DOT_MIN_LSB = DLY_W'(
    (DOT_MIN_FS * (64'd1 << FINE_W) + CLK_PERIOD_FS - 1) / CLK_PERIOD_FS);
  localparam logic [DLY_W-1:0] DOT_MAX_LSB = DLY_W'(
    (DOT_MAX_FS * (64'd1 << FINE_W)) / CLK_PERIOD_FS);
  localparam int          IDX_W           = 16;

  // =====================================================================
  // controller address map
  localparam int          ADDR_W          = 20;
  localparam logic [ADDR_W-1:0] ROM_BASE  = 20'hc_0000;
  localparam logic [ADDR_W-1:0] SRAM_TOP  = 20'h2_0000;
  localparam logic [ADDR_W-1:0] MBOX_BASE = 20'h2_0000;
  localparam int          MBOX_AW         = 14;
  localparam int          MBOX_DW         = 8;

  // =====================================================================
  // reset values of the configuration bits
  localparam logic        HF_RST          = 1'h0;
  localparam logic        ENH_RST         = 1'h0;
  localparam logic        AUTO_RST        = 1'h1;
  localparam logic        MANUAL_RST      = 1'h0;

  typedef enum logic [2:0] {
    ST_ARMED = 3'h1,
    ST_DELAY = 3'h2,
    ST_HOLD  = 3'h4
  } tb_state_type;

endpackage

/* File: hdl/coarse_counter.sv */
// one six-bit down-counting stage of the coarse strobe delay chain
// assumes stages are cascaded through borrow_out into the next dec_in
`timescale 1ns/1ps
module coarse_counter
  import timebase_pkg::*;
#(
  parameter int W = COARSE_W
) (
  // clock and reset
  input  logic         clk,
  input  logic         rst_b,
  // control
  input  logic         load,
  input  logic [W-1:0] load_val,
  input  logic         dec_in,
  // status
  output logic         zero,
  output logic         borrow_out
);

  logic [W-1:0] count_reg;

  // =====================================================================
  // load wins over decrement so a new trigger always restarts the count
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_val;
    end else if (dec_in) begin
      count_reg <= count_reg - W'(1);
    end
  end

  assign zero       = (count_reg == '0);
  assign borrow_out = dec_in & zero;  // wraps to all ones, borrows above

endmodule

/* File: hdl/mailbox_ram.sv */
// shared mailbox memory between the controller and the acquisition side
// assumes both ports on the one clock; read data come out of a register
`timescale 1ns/1ps
module mailbox_ram
  import timebase_pkg::*;
#(
  parameter int AW = MBOX_AW,
  parameter int DW = MBOX_DW
) (
  // clock
  input  logic          clk,
  // controller port
  input  logic          a_en,
  input  logic          a_wr,
  input  logic [AW-1:0] a_addr,
  input  logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  // acquisition port
  input  logic          b_wr,
  input  logic [AW-1:0] b_addr,
  input  logic [DW-1:0] b_wdata,
  output logic [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [0:(1 << AW)-1];

  // =====================================================================
  // on a same-address double write the controller is written last, wins
  always_ff @(posedge clk) begin
    if (b_wr) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_en && a_wr) begin
      mem[a_addr] <= a_wdata;
    end
  end

  // registered reads, old data on a read during write
  always_ff @(posedge clk) begin
    if (a_en) begin
      a_rdata <= mem[a_addr];
    end
    b_rdata <= mem[b_addr];
  end

endmodule

/* File: hdl/trigger_holdoff_strobe_timebase.sv */
// trigger qualification, holdoff timing and strobe delay sequencing
// assumes pins trig_pin and meta_pin are asynchronous to clk; all other
// inputs come from controller logic on clk
//
// What this block does
// - auto mode: fire an internal trigger after 20 ms without one
// - normal mode: never fire internally, wait for a real trigger
// - high frequency select drops hysteresis; off after reset
// - enhanced on: metastable sample discarded, retaken on next trigger
// - enhanced off: metastable samples pass as normal samples
// - auto holdoff is default; recomputed on record size or position change
// - auto holdoff is max of 5 us and 5 us plus position plus duration
// - duration is record size per division times 10
// - manual holdoff is the larger of the auto value and the requested holdoff, up to 2.5 s
// - first strobe at start delay, each next one dot delay later
// - dot delay is held in a 48-bit strobe delay register
// - dot delay range is 10 fs to 20 ns
// - coarse timing is three six-bit counters feeding the delay generator
// - one strobe drive pulse per accepted trigger after the delay
// - top 256 KB of 1 MB space is ROM, bottom 128 KB is SRAM
// - 16 KB shared RAM mapped like ordinary RAM for the controller
// - shared RAM is the command and data mailbox of both sides
`timescale 1ns/1ps
module trigger_holdoff_strobe_timebase
  import timebase_pkg::*;
#(
  parameter logic [TW-1:0] AUTO_CYC    = TW'(AUTO_TRIG_CYC),
  parameter logic [TW-1:0] REQ_MAX_CYC = TW'(REQ_HOLD_MAX_CYC)
) (
  // clock and reset
  input  logic                 clk,
  input  logic                 rst_b,
  // trigger pins
  input  logic                 trig_pin,
  input  logic                 meta_pin,
  // configuration
  input  logic                 run_en,
  input  logic                 cfg_wr,
  input  logic                 cfg_auto,
  input  logic                 cfg_hf,
  input  logic                 cfg_enh,
  input  logic                 cfg_manual,
  input  logic [DLY_W-1:0]     start_delay,
  input  logic [IDX_W-1:0]     record_points,
  input  logic                 dot_wr,
  input  logic [DLY_W-1:0]     dot_in,
  // holdoff settings, in clock cycles
  input  logic [TW-1:0]        main_pos,
  input  logic [TW-1:0]        main_size,
  input  logic [TW-1:0]        req_holdoff,
  // trigger path and strobe outputs
  output logic                 hyst_keep,
  output logic                 strobe_drive,
  output logic [FINE_W-1:0]    fine_delay,
  output logic                 sample_valid,
  output logic                 sample_reject,
  output logic                 record_done,
  output logic [IDX_W-1:0]     sample_idx,
  output logic [DLY_W-1:0]     dot_delay,
  output logic [TW-1:0]        actual_holdoff,
  output logic                 armed,
  // controller memory port
  input  logic [ADDR_W-1:0]    ctl_addr,
  input  logic                 ctl_rd,
  input  logic                 ctl_wr,
  input  logic [MBOX_DW-1:0]   ctl_wdata,
  output logic                 rom_sel,
  output logic                 sram_sel,
  output logic                 mbox_sel,
  output logic [MBOX_DW-1:0]   ctl_rdata,
  // acquisition mailbox port
  input  logic [MBOX_AW-1:0]   acq_addr,
  input  logic                 acq_wr,
  input  logic [MBOX_DW-1:0]   acq_wdata,
  output logic [MBOX_DW-1:0]   acq_rdata
);

  localparam int CW = COARSE_W * N_COARSE;

  tb_state_type        state_reg;
  logic [1:0]          trig_sync_reg;
  logic [1:0]          meta_sync_reg;
  logic                trig_prev_reg;
  logic                auto_reg;
  logic                hf_reg;
  logic                enh_reg;
  logic                manual_reg;
  logic                meta_cap_reg;
  logic [TW-1:0]       auto_cnt_reg;
  logic [TW-1:0]       hold_cnt_reg;
  logic [TW-1:0]       pos_seen_reg;
  logic [TW-1:0]       size_seen_reg;
  logic [TW-1:0]       req_seen_reg;
  logic                man_seen_reg;
  logic [DLY_W-1:0]    delay_acc_reg;
  logic [TW-1:0]       hold_calc;
  logic                trig_edge;
  logic                auto_fire;
  logic                accept;
  logic                strobe;
  logic                last_sample;
  logic                all_zero;
  logic [N_COARSE:0]   dec_chain;
  logic [N_COARSE-1:0] zero_v;
  logic [CW-1:0]       coarse_val;

  // =====================================================================
  // holdoff arithmetic, saturating at the counter width
  function automatic logic [TW-1:0] holdoff_calc(
    input logic [TW-1:0] pos,
    input logic [TW-1:0] size,
    input logic [TW-1:0] req,
    input logic          manual,
    input logic [TW-1:0] req_max
  );
    logic [TW+4:0] dur;
    logic [TW+4:0] sum;
    logic [TW-1:0] auto_v;
    logic [TW-1:0] req_c;
    dur    = (TW+5)'(size) * (TW+5)'(DIVISIONS);
    sum    = (TW+5)'(HOLD_MIN_CYC) + (TW+5)'(pos) + dur;
    auto_v = (sum[TW+4:TW] != '0) ? '1 : sum[TW-1:0];
    if (auto_v < TW'(HOLD_MIN_CYC)) begin
      auto_v = TW'(HOLD_MIN_CYC);
    end
    req_c  = (req > req_max) ? req_max : req;
    holdoff_calc = (manual && req_c > auto_v) ? req_c : auto_v;
  endfunction

  // =====================================================================
  // pin synchronisers; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trig_sync_reg <= 2'h0;
      meta_sync_reg <= 2'h0;
      trig_prev_reg <= 1'h0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[0], trig_pin};
      meta_sync_reg <= {meta_sync_reg[0], meta_pin};
      trig_prev_reg <= trig_sync_reg[1];
    end
  end

  assign trig_edge = trig_sync_reg[1] & ~trig_prev_reg;

  // =====================================================================
  // mode bits; all change together on a configuration write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      auto_reg   <= AUTO_RST;
      hf_reg     <= HF_RST;
      enh_reg    <= ENH_RST;
      manual_reg <= MANUAL_RST;
    end else if (cfg_wr) begin
      auto_reg   <= cfg_auto;
      hf_reg     <= cfg_hf;
      enh_reg    <= cfg_enh;
      manual_reg <= cfg_manual;
    end
  end

  assign hyst_keep = ~hf_reg;

  // =====================================================================
  // dot delay register, clamped into the supported range on write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dot_delay <= DOT_MIN_LSB;
    end else if (dot_wr) begin
      if (dot_in < DOT_MIN_LSB) begin
        dot_delay <= DOT_MIN_LSB;
      end else if (dot_in > DOT_MAX_LSB) begin
        dot_delay <= DOT_MAX_LSB;
      end else begin
        dot_delay <= dot_in;
      end
    end
  end

  // =====================================================================
  // holdoff recomputed only when a setting it depends on changes
  assign hold_calc = holdoff_calc(main_pos, main_size, req_holdoff,
                                  manual_reg, REQ_MAX_CYC);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      actual_holdoff <= TW'(HOLD_MIN_CYC);
      pos_seen_reg   <= '0;
      size_seen_reg  <= '0;
      req_seen_reg   <= '0;
      man_seen_reg   <= MANUAL_RST;
    end else begin
      pos_seen_reg  <= main_pos;
      size_seen_reg <= main_size;
      req_seen_reg  <= req_holdoff;
      man_seen_reg  <= manual_reg;
      if (main_pos != pos_seen_reg || main_size != size_seen_reg ||
          req_holdoff != req_seen_reg || manual_reg != man_seen_reg) begin
        actual_holdoff <= hold_calc;
      end
    end
  end

  // =====================================================================
  // trigger acceptance; only the armed state listens at all
  assign auto_fire = auto_reg && (auto_cnt_reg == AUTO_CYC - TW'(1));
  assign accept    = (state_reg == ST_ARMED) && run_en &&
                     (trig_edge || auto_fire);

  // auto timeout only counts while armed, so it restarts at every
  // acceptance and again from zero when holdoff ends
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      auto_cnt_reg <= '0;
    end else if (state_reg != ST_ARMED || accept || !run_en) begin
      auto_cnt_reg <= '0;
    end else if (auto_reg) begin
      auto_cnt_reg <= auto_cnt_reg + TW'(1);
    end
  end

  // holdoff timer: cycles since acceptance, saturating
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_cnt_reg <= '0;
    end else if (accept) begin
      hold_cnt_reg <= TW'(1);
    end else if (state_reg != ST_ARMED && hold_cnt_reg != '1) begin
      hold_cnt_reg <= hold_cnt_reg + TW'(1);
    end
  end

  // =====================================================================
  // coarse delay: three cascaded six-bit stages of the accumulator
  assign coarse_val   = delay_acc_reg[DLY_W-1 -: CW];
  assign all_zero     = &zero_v;
  assign dec_chain[0] = (state_reg == ST_DELAY) && !all_zero;

  for (genvar g = 0; g < N_COARSE; g++) begin : g_coarse
    coarse_counter #(
      .W          (COARSE_W)
    ) u_stage (
      .clk        (clk),
      .rst_b      (rst_b),
      .load       (accept),
      .load_val   (coarse_val[g*COARSE_W +: COARSE_W]),
      .dec_in     (dec_chain[g]),
      .zero       (zero_v[g]),
      .borrow_out (dec_chain[g+1])
    );
  end

  assign strobe = (state_reg == ST_DELAY) && all_zero;

  // fine part goes to the analog vernier, latched at acceptance
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fine_delay   <= '0;
      meta_cap_reg <= 1'h0;
    end else if (accept) begin
      fine_delay   <= delay_acc_reg[FINE_W-1:0];
      meta_cap_reg <= meta_sync_reg[1];
    end
  end

  // =====================================================================
  // sequencer: armed, counting the delay, then sitting out the holdoff
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= ST_ARMED;
    end else begin
      unique case (state_reg)
        ST_ARMED: begin
          if (accept) begin
            state_reg <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (strobe) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (hold_cnt_reg >= actual_holdoff) begin
            state_reg <= ST_ARMED;
          end
        end
      endcase
    end
  end

  assign armed = (state_reg == ST_ARMED);

  // =====================================================================
  // per-sample delay stepping; a rejected sample keeps its slot
  assign last_sample = (32'(sample_idx) + 32'd1 >= 32'(record_points));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      delay_acc_reg <= '0;
      sample_idx    <= '0;
    end else if (cfg_wr) begin
      delay_acc_reg <= start_delay;
      sample_idx    <= '0;
    end else if (strobe && !(enh_reg && meta_cap_reg)) begin
      if (last_sample) begin
        delay_acc_reg <= start_delay;
        sample_idx    <= '0;
      end else begin
        delay_acc_reg <= delay_acc_reg + dot_delay;
        sample_idx    <= sample_idx + IDX_W'(1);
      end
    end
  end

  // registered one-cycle outputs, one clock behind the internal strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strobe_drive  <= 1'h0;
      sample_valid  <= 1'h0;
      sample_reject <= 1'h0;
      record_done   <= 1'h0;
    end else begin
      strobe_drive  <= strobe;
      sample_valid  <= strobe && !(enh_reg && meta_cap_reg);
      sample_reject <= strobe && enh_reg && meta_cap_reg;
      record_done   <= strobe && !(enh_reg && meta_cap_reg) && last_sample;
    end
  end

  // =====================================================================
  // controller address decode and the shared mailbox
  assign rom_sel  = (ctl_addr >= ROM_BASE);
  assign sram_sel = (ctl_addr < SRAM_TOP);
  assign mbox_sel = (ctl_addr[ADDR_W-1:MBOX_AW] ==
                     MBOX_BASE[ADDR_W-1:MBOX_AW]);

  mailbox_ram #(
    .AW      (MBOX_AW),
    .DW      (MBOX_DW)
  ) u_mbox (
    .clk     (clk),
    .a_en    (mbox_sel && (ctl_rd || ctl_wr)),
    .a_wr    (ctl_wr),
    .a_addr  (ctl_addr[MBOX_AW-1:0]),
    .a_wdata (ctl_wdata),
    .a_rdata (ctl_rdata),
    .b_wr    (acq_wr),
    .b_addr  (acq_addr),
    .b_wdata (acq_wdata),
    .b_rdata (acq_rdata)
  );

  // =====================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence acc_s;
    accept ##1 (state_reg == ST_DELAY);
  endsequence

  auto_timeout_fire_a: assert property (
    (armed && run_en && auto_reg && auto_cnt_reg == AUTO_CYC - TW'(1))
    |-> acc_s)
    else $error("auto trigger did not fire on timeout");

  normal_no_auto_a: assert property (
    (accept && !auto_reg) |-> trig_edge)
    else $error("internal trigger in normal mode");

  hf_hyst_a: assert property (
    (cfg_wr && cfg_hf) |=> !hyst_keep ##1 (hyst_keep == !hf_reg))
    else $error("hysteresis not removed by high frequency select");

  meta_reject_a: assert property (
    (strobe && enh_reg && meta_cap_reg && !cfg_wr)
    |=> sample_reject && $stable(sample_idx) && $stable(delay_acc_reg))
    else $error("metastable sample not discarded");

  meta_pass_a: assert property (
    (strobe && !enh_reg) |=> sample_valid && !sample_reject)
    else $error("sample wrongly rejected with enhanced off");

  holdoff_update_a: assert property (
    ($changed(main_size) || $changed(main_pos))
    |=> actual_holdoff == $past(hold_calc))
    else $error("holdoff not recomputed on setting change");

  holdoff_floor_a: assert property (
    actual_holdoff >= TW'(HOLD_MIN_CYC))
    else $error("holdoff below the minimum");

  manual_req_a: assert property (
    ($changed(req_holdoff) && manual_reg && req_holdoff <= REQ_MAX_CYC)
    |=> actual_holdoff >= $past(req_holdoff))
    else $error("manual holdoff below the request");

  dot_step_a: assert property (
    (strobe && !(enh_reg && meta_cap_reg) && !last_sample && !cfg_wr)
    |=> delay_acc_reg == $past(delay_acc_reg) + $past(dot_delay))
    else $error("sample delay did not step by one dot delay");

  strobe_zero_a: assert property (
    (accept && coarse_val == '0) |=> strobe ##1 strobe_drive)
    else $error("no strobe after zero coarse delay");

  holdoff_hold_a: assert property (
    (state_reg == ST_HOLD && hold_cnt_reg < actual_holdoff)
    |=> !armed && !accept)
    else $error("trigger accepted inside holdoff");

  auto_restart_a: assert property (
    accept |=> auto_cnt_reg == '0)
    else $error("auto timeout not restarted");

endmodule

/* File: bench/trig_source.sv */
// trigger input path model: turns a one-cycle fire request into a pin pulse
// assumes fire and meta come from the bench on the falling edge of clk
`timescale 1ns/1ps
module trig_source (
  // clock
  input  wire logic clk,
  // requests from the bench
  input  wire logic fire,
  input  wire logic meta,
  // trigger pins
  output logic      trig_pin,
  output logic      meta_pin
);
  // =====================================================================
  // pulse
  logic [1:0] left_reg;
  initial begin
    trig_pin = 1'b0;
    meta_pin = 1'b0;
    left_reg = 2'h0;
  end
  // three cycles high so the two-flop sync always sees the edge
  always @(posedge clk) begin
    if (fire) begin
      trig_pin <= 1'b1;
      meta_pin <= meta;
      left_reg <= 2'h2;
    end else if (left_reg != 2'h0) begin
      left_reg <= left_reg - 2'h1;
    end else begin
      trig_pin <= 1'b0; // idle low between events
      meta_pin <= 1'b0; // no stale metastable flag once the pulse ends
    end
  end
endmodule

/* File: bench/test_trigger_holdoff_strobe_timebase.sv */
// sequence tests of trigger, holdoff, strobe and mailbox behaviour
// assumes AUTO_CYC 40 and REQ_MAX_CYC 1000 to keep the run short
`timescale 1ns/1ps
module test_trigger_holdoff_strobe_timebase
  import timebase_pkg::*;
;
  // =====================================================================
  // signals
  logic clk = 0, rst_b = 0, run_en = 1, cfg_wr = 0, dot_wr = 0;
  logic cfg_auto = 0, cfg_hf = 0, cfg_enh = 0, cfg_manual = 0;
  logic fire = 0, meta = 0, trig_pin, meta_pin, ctl_rd = 0, ctl_wr = 0;
  logic [DLY_W-1:0] start_delay = '0, dot_in = '0, dot_delay;
  logic [IDX_W-1:0] record_points = 16'h0004, sample_idx;
  logic [TW-1:0] main_pos = '0, main_size = '0, req_holdoff = '0;
  logic [TW-1:0] actual_holdoff;
  logic [FINE_W-1:0] fine_delay;
  logic hyst_keep, strobe_drive, sample_valid, sample_reject;
  logic record_done, armed, rom_sel, sram_sel, mbox_sel, acq_wr = 0;
  logic [ADDR_W-1:0] ctl_addr = '0;
  logic [MBOX_AW-1:0] acq_addr = '0;
  logic [MBOX_DW-1:0] ctl_wdata = '0, acq_wdata = '0, ctl_rdata, acq_rdata;
  int error_cnt = 0, total_checks = 0, sc = 0, rc = 0, s0;
  int cyc = 0, f0 = 0, st = 0, vc = 0, dc = 0;

  always #50 clk = ~clk;
  trig_source trig_source_inst (.clk, .fire, .meta, .trig_pin, .meta_pin);
  trigger_holdoff_strobe_timebase #(.AUTO_CYC(32'h0000_0028),
    .REQ_MAX_CYC(32'h0000_03e8)) trigger_holdoff_strobe_timebase_inst (
    .clk, .rst_b, .trig_pin, .meta_pin, .run_en, .cfg_wr, .cfg_auto,
    .cfg_hf, .cfg_enh, .cfg_manual, .start_delay, .record_points, .dot_wr,
    .dot_in, .main_pos, .main_size, .req_holdoff, .hyst_keep, .strobe_drive,
    .fine_delay, .sample_valid, .sample_reject, .record_done, .sample_idx,
    .dot_delay, .actual_holdoff, .armed, .ctl_addr, .ctl_rd, .ctl_wr,
    .ctl_wdata, .rom_sel, .sram_sel, .mbox_sel, .ctl_rdata, .acq_addr,
    .acq_wr, .acq_wdata, .acq_rdata);

  // one-cycle pulses are counted as they stand; fire and strobe cycles
  // are logged so that the trigger to strobe latency can be measured
  always @(posedge clk) begin
    cyc++;
    if (fire === 1'b1) f0 = cyc;
    if (strobe_drive === 1'b1) begin
      sc++;
      st = cyc;
    end
    if (sample_reject === 1'b1) rc++;
    if (sample_valid === 1'b1) vc++;
    if (record_done === 1'b1) dc++;
  end

  // =====================================================================
  // tasks
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cfg(input logic a, h, e, m);
    @(negedge clk) {cfg_auto, cfg_hf, cfg_enh, cfg_manual} = {a, h, e, m};
    cfg_wr = 1;
    @(negedge clk) cfg_wr = 0;
  endtask
  task automatic shot(input logic m, input int n);
    @(negedge clk) {fire, meta} = {1'b1, m};
    @(negedge clk) fire = 0;
    tick(n);
  endtask
  task automatic dec(input logic [19:0] a, input logic [2:0] e);
    @(negedge clk) ctl_addr = a;
    #1 chk("decode", 48'({rom_sel, sram_sel, mbox_sel}), 48'(e));
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(5000 * 100);
    error_cnt++;
    close_out();
  end

  // =====================================================================
  // main sequence
  initial begin
    tick(3);
    rst_b = 1;
    chk("hyst", 48'(hyst_keep), 48'h1);
    chk("hold", 48'(actual_holdoff), 48'd50);
    chk("dot", dot_delay, 48'(DOT_MIN_LSB));
    cfg(0, 1, 1, 0);
    chk("hyst", 48'(hyst_keep), 48'h0);
    @(negedge clk) {dot_wr, dot_in} = {1'b1, 48'h0000_0000_03e8};
    @(negedge clk) {dot_wr, dot_in} = {1'b1, 48'h0};
    chk("dot", dot_delay, 48'h0000_0000_03e8);
    @(negedge clk) dot_wr = 0;
    chk("dot", dot_delay, 48'(DOT_MIN_LSB));
    tick(100);
    chk("strobes", 48'(sc), 48'd0);
    shot(1, 80);
    chk("strobes", 48'(sc), 48'd1);
    chk("rejects", 48'(rc), 48'd1);
    chk("idx", 48'(sample_idx), 48'd0);
    shot(0, 80);
    chk("idx", 48'(sample_idx), 48'd1);
    // model, two sync flops, accept and output flop: 5 cycles at coarse 0
    chk("lat", 48'(st - f0), 48'd5);
    shot(0, 10);
    chk("armed", 48'(armed), 48'h0);
    shot(0, 80);
    chk("strobes", 48'(sc), 48'd3);
    cfg(0, 0, 0, 0);
    shot(1, 80);
    chk("idx", 48'(sample_idx), 48'd1);
    chk("rejects", 48'(rc), 48'd1);
    chk("valid", 48'(vc), 48'd3);
    s0 = sc;
    cfg(1, 0, 0, 0);
    tick(150);
    chk("auto", 48'(sc > s0), 48'd1);
    // start delay of 3 coarse cycles above a fine part, two-point record
    start_delay = 48'h0000_c000_1234;
    record_points = 16'h0002; // interval is span over points
    cfg(0, 0, 0, 0);
    tick(60);
    shot(0, 80);
    chk("lat", 48'(st - f0), 48'd8);
    chk("fine", 48'(fine_delay), 48'h1234);
    shot(0, 80);
    chk("fine", 48'(fine_delay), 48'h1234 + 48'(DOT_MIN_LSB));
    chk("done", 48'(dc), 48'd1);
    chk("idx", 48'(sample_idx), 48'd0);
    shot(0, 80);
    chk("fine", 48'(fine_delay), 48'h1234);
    @(negedge clk) {main_pos, main_size} = {32'h0000_000a, 32'h0000_0003};
    tick(3);
    chk("hold", 48'(actual_holdoff), 48'd90);
    req_holdoff = 32'h0000_01f4;
    cfg(0, 0, 0, 1);
    tick(3);
    chk("hold", 48'(actual_holdoff), 48'd500);
    req_holdoff = 32'h0000_1388;
    tick(3);
    chk("hold", 48'(actual_holdoff), 48'd1000);
    dec(20'hc_0000, 3'h4);
    dec(20'h1_ffff, 3'h2);
    dec(20'h2_4000, 3'h0);
    dec(20'h2_0010, 3'h1);
    @(negedge clk) {ctl_wr, ctl_wdata} = {1'b1, 8'h5a};
    @(negedge clk) {ctl_wr, acq_addr} = {1'b0, 14'h0010};
    @(negedge clk) {acq_wr, acq_addr, acq_wdata} = {1'b1, 14'h0020, 8'ha5};
    chk("acq", 48'(acq_rdata), 48'h5a);
    @(negedge clk) {acq_wr, ctl_addr, ctl_rd} = {1'b0, 20'h2_0020, 1'b1};
    @(negedge clk) ctl_rd = 0;
    chk("ctl", 48'(ctl_rdata), 48'ha5);
    // reset in mid-run: state falls back, holdoff follows the settings
    @(negedge clk) rst_b = 0;
    tick(2);
    chk("hold", 48'(actual_holdoff), 48'd50);
    chk("armed", 48'(armed), 48'h1);
    chk("idx", 48'(sample_idx), 48'd0);
    rst_b = 1;
    tick(2);
    chk("hold", 48'(actual_holdoff), 48'd90);
    chk("pairs", 48'(vc + rc), 48'(sc));
    close_out();
  end
endmodule
